// [rtl/brm_ahb_rom.sv]
// Boot ROM AHB slave with Avalon-MM configuration registers
//
// Overview of operation
// - 128 kB 32-bit ROM at base 0x12000000
// - Full AHB slave with ready and response
// - Software selects 0, 1 or 2 waits
// - Single main clock, at most 75 MHz
// - Reset loads its reset values into all logic of the block
// - DMA reads allowed, no flow-control handshake
// - Page-translation table 16 kB at 0x1201C000
// - Checksum lookup table at 0x12015CBC
// - Holds boot code fetched after reset
// - First 4 kB shadowed at zero after reset
`timescale 1ns/1ps
module brm_ahb_rom #(
    parameter logic [31:0] BOOT_FILL = 32'h0000_0000
) (
    input  wire logic        clock_i,
    input  wire logic        rst_n_i,
    input  wire logic        ce_i,
    // AHB slave port
    input  wire logic        hsel_i,
    input  wire logic [31:0] haddr_i,
    input  wire logic [1:0]  htrans_i,
    input  wire logic        hwrite_i,
    input  wire logic [2:0]  hsize_i,
    input  wire logic        hready_i,
    output logic             hreadyout_o,
    output logic      [1:0]  hresp_o,
    output logic      [31:0] hrdata_o,
    // Avalon-MM register port
    input  wire logic [31:0] avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o
);

    // ************************************************************
    // State record
    // ************************************************************
    typedef struct packed {
        brm_pkg::brm_state_e state;
        logic [1:0]          wait_cnt;
        logic [14:0]         addr_idx;
        logic [1:0]          lat;
        logic                shadow_en;
        logic                write_seen;
        logic                hreadyout;
        logic [1:0]          hresp;
        logic [31:0]         hrdata;
        logic                av_wait;
        logic [31:0]         av_rdata;
    } brm_regs_s;

    localparam brm_regs_s REGS_RST = '{
        state:      brm_pkg::BRM_IDLE,
        wait_cnt:   2'h0,
        addr_idx:   15'h0000,
        lat:        brm_pkg::LAT_RST,
        shadow_en:  brm_pkg::SHADOW_RST,
        write_seen: 1'b0,
        hreadyout:  1'b1,
        hresp:      brm_pkg::HRESP_OKAY,
        hrdata:     32'h0000_0000,
        av_wait:    1'b1,
        av_rdata:   32'h0000_0000
    };

    brm_regs_s   r_reg;
    brm_regs_s   r_next;
    logic        accept;
    logic        in_rom;
    logic        in_shadow;
    logic [14:0] req_idx;
    logic [14:0] rd_idx;
    logic [31:0] rom_word;
    logic [1:0]  eff_lat;

    // ************************************************************
    // Address decode
    // ************************************************************
    // Transfer taken on NONSEQ or SEQ
    assign accept    = hsel_i && hready_i && htrans_i[1];
    assign in_rom    = haddr_i[31:brm_pkg::ROM_DEC_LSB]
                     == brm_pkg::ROM_BASE[31:brm_pkg::ROM_DEC_LSB];
    assign in_shadow = r_reg.shadow_en
                     && haddr_i[31:brm_pkg::SHADOW_DEC_LSB]
                     == brm_pkg::SHADOW_BASE[31:brm_pkg::SHADOW_DEC_LSB];
    // Shadow hits take only the page offset, so they map onto word 0 up
    assign req_idx   = in_rom ? haddr_i[16:2]
                              : {5'h00, haddr_i[brm_pkg::SHADOW_DEC_LSB-1:2]};
    assign rd_idx    = accept ? req_idx : r_reg.addr_idx;
    // Setting 3 is not defined, so it is held to the largest legal value
    assign eff_lat   = (r_reg.lat > brm_pkg::LAT_MAX) ? brm_pkg::LAT_MAX : r_reg.lat;

    // ************************************************************
    // Contents
    // ************************************************************
    brm_rom_content #(
        .BOOT_FILL (BOOT_FILL)
    ) u_content (
        .idx_i  (rd_idx),
        .word_o (rom_word)
    );

    // ************************************************************
    // Next-state logic
    // ************************************************************
    always_comb begin
        r_next = r_reg;
        // Response returns to OKAY once the previous phase has ended
        if (r_reg.hreadyout) begin
            r_next.hresp = brm_pkg::HRESP_OKAY;
        end
        // AHB data phase progress
        case (r_reg.state)
            brm_pkg::BRM_IDLE: begin
            end
            brm_pkg::BRM_WAIT: begin
                if (r_reg.wait_cnt == 2'h1) begin
                    r_next.hreadyout = 1'b1;
                    r_next.hrdata    = rom_word;
                    r_next.state     = brm_pkg::BRM_IDLE;
                end else begin
                    r_next.wait_cnt = r_reg.wait_cnt - 2'h1;
                end
            end
            brm_pkg::BRM_ERR: begin
                r_next.hreadyout = 1'b1;
                r_next.state     = brm_pkg::BRM_IDLE;
            end
            default: begin
                r_next.state = brm_pkg::BRM_IDLE;
            end
        endcase
        // Any master, processor or DMA, served alike
        if (accept) begin
            r_next.addr_idx = req_idx;
            if (!(in_rom || in_shadow)) begin
                r_next.state     = brm_pkg::BRM_ERR;
                r_next.hreadyout = 1'b0;
                r_next.hresp     = brm_pkg::HRESP_ERROR;
            end else begin
                // Write is completed, nothing is stored
                if (hwrite_i) begin
                    r_next.write_seen = 1'b1;
                end
                if (eff_lat == 2'h0) begin
                    r_next.hreadyout = 1'b1;
                    r_next.hrdata    = rom_word;
                    r_next.state     = brm_pkg::BRM_IDLE;
                end else begin
                    r_next.hreadyout = 1'b0;
                    r_next.wait_cnt  = eff_lat;
                    r_next.state     = brm_pkg::BRM_WAIT;
                end
            end
        end
        // Avalon: answer one cycle after the request is seen
        if (!r_reg.av_wait) begin
            r_next.av_wait = 1'b1;
            if (avs_write_i) begin
                if (avs_address_i == brm_pkg::LAT_ADDR && avs_byteenable_i[0]) begin
                    r_next.lat = avs_writedata_i[brm_pkg::LAT_LSB +: 2];
                end
                if (avs_address_i == brm_pkg::CTRL_ADDR && avs_byteenable_i[0]) begin
                    r_next.shadow_en = avs_writedata_i[brm_pkg::CTRL_SHADOW];
                end
                // Write-one clear; a same-cycle AHB write keeps the flag set
                if (avs_address_i == brm_pkg::STAT_ADDR && avs_byteenable_i[0]
                        && avs_writedata_i[brm_pkg::STAT_WRSEEN]
                        && !(accept && hwrite_i && (in_rom || in_shadow))) begin
                    r_next.write_seen = 1'b0;
                end
            end
        end else if (avs_read_i || avs_write_i) begin
            r_next.av_wait  = 1'b0;
            r_next.av_rdata = 32'h0000_0000;
            if (avs_read_i) begin
                if (avs_address_i == brm_pkg::LAT_ADDR) begin
                    r_next.av_rdata[brm_pkg::LAT_LSB +: 2] = r_reg.lat;
                end else if (avs_address_i == brm_pkg::CTRL_ADDR) begin
                    r_next.av_rdata[brm_pkg::CTRL_SHADOW] = r_reg.shadow_en;
                end else if (avs_address_i == brm_pkg::STAT_ADDR) begin
                    r_next.av_rdata[brm_pkg::STAT_BUSY]   = r_reg.state != brm_pkg::BRM_IDLE;
                    r_next.av_rdata[brm_pkg::STAT_WRSEEN] = r_reg.write_seen;
                end
            end
        end
    end

    // ************************************************************
    // State register
    // ************************************************************
    // One clock for everything
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            r_reg <= REGS_RST;
        end else if (ce_i) begin
            r_reg <= r_next;
        end
    end

    // ************************************************************
    // Outputs, all straight from the record
    // ************************************************************
    assign hreadyout_o       = r_reg.hreadyout;
    assign hresp_o           = r_reg.hresp;
    assign hrdata_o          = r_reg.hrdata;
    assign avs_readdata_o    = r_reg.av_rdata;
    assign avs_waitrequest_o = r_reg.av_wait;

endmodule : brm_ahb_rom

// [shared/brm_pkg.sv]
// Shared constants and types for the boot ROM AHB slave
package brm_pkg;

    // ************************************************************
    // Memory map of the ROM and its windows
    // ************************************************************
    localparam logic [31:0] ROM_BASE       = 32'h1200_0000;
    localparam int          ROM_BYTES      = 131072;
    localparam int          ROM_WORDS      = 32768;
    localparam int          IDX_W          = 15;
    localparam int          ROM_DEC_LSB    = 17;
    localparam logic [31:0] SHADOW_BASE    = 32'h0000_0000;
    localparam int          SHADOW_DEC_LSB = 12;
    localparam int          SHADOW_IDX_W   = 10;

    // ************************************************************
    // Contents layout: page table and checksum table
    // ************************************************************
    localparam logic [31:0] PT_BASE        = 32'h1201_c000;
    localparam logic [14:0] PT_IDX         = 15'h7000;
    localparam int          PT_ENTRIES     = 4096;
    localparam logic [19:0] PT_ATTR        = 20'h00c12;
    localparam logic [31:0] CRC_BASE       = 32'h1201_5cbc;
    localparam logic [14:0] CRC_IDX        = 15'h572f;
    localparam logic [14:0] CRC_END_IDX    = 15'h582f;
    localparam logic [31:0] CRC_POLY       = 32'hedb8_8320;
    localparam int          CRC_BIT_STEPS  = 8;

    // ************************************************************
    // Register addresses, fields and reset values
    // ************************************************************
    localparam logic [31:0] LAT_ADDR       = 32'h1300_2860;
    localparam logic [31:0] CTRL_ADDR      = 32'h1300_2864;
    localparam logic [31:0] STAT_ADDR      = 32'h1300_2868;
    localparam int          LAT_LSB        = 0;
    localparam int          CTRL_SHADOW    = 0;
    localparam int          STAT_BUSY      = 0;
    localparam int          STAT_WRSEEN    = 1;
    localparam logic [1:0]  LAT_RST        = 2'h2;
    localparam logic [1:0]  LAT_MAX        = 2'h2;
    localparam logic        SHADOW_RST     = 1'b1;

    // ************************************************************
    // Bus encodings and timing
    // ************************************************************
    localparam logic [1:0]  HRESP_OKAY     = 2'h0;
    localparam logic [1:0]  HRESP_ERROR    = 2'h1;
    localparam int          MAX_CLK_MHZ    = 75;

    typedef enum logic [1:0] {
        BRM_IDLE,
        BRM_WAIT,
        BRM_ERR
    } brm_state_e;

endpackage : brm_pkg

// [rtl/brm_rom_content.sv]
// Combinational ROM contents: boot area, checksum table, page table
`timescale 1ns/1ps
module brm_rom_content #(
    parameter logic [31:0] BOOT_FILL = 32'h0000_0000
) (
    input  wire logic [14:0] idx_i,
    output logic      [31:0] word_o
);

    // ************************************************************
    // Word generator
    // ************************************************************
    // Tables are built from their formulas, so no image file is needed
    always_comb begin
        logic [14:0] rel_crc;
        logic [14:0] rel_pt;
        logic [31:0] c;
        rel_crc = idx_i - brm_pkg::CRC_IDX;
        rel_pt  = idx_i - brm_pkg::PT_IDX;
        c       = {24'h00_0000, rel_crc[7:0]};
        word_o  = BOOT_FILL;
        if (idx_i >= brm_pkg::PT_IDX) begin
            word_o = {rel_pt[11:0], brm_pkg::PT_ATTR};
        end else if (idx_i >= brm_pkg::CRC_IDX && idx_i < brm_pkg::CRC_END_IDX) begin
            for (int k = 0; k < brm_pkg::CRC_BIT_STEPS; k++) begin
                c = c[0] ? ((c >> 1) ^ brm_pkg::CRC_POLY) : (c >> 1);
            end
            word_o = c;
        end
    end

endmodule : brm_rom_content

// [verif/brm_ahb_rom_props.sv]
// Port checker for the boot ROM slave, bound into its top module
`timescale 1ns/1ps
module brm_ahb_rom_props (
    input wire logic        clock_i,
    input wire logic        rst_n_i,
    input wire logic        hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0]  htrans_i,
    input wire logic        hready_i,
    input wire logic        hreadyout_o,
    input wire logic [1:0]  hresp_o,
    input wire logic [31:0] hrdata_o,
    input wire logic [31:0] avs_address_i,
    input wire logic        avs_read_i,
    input wire logic        avs_write_i,
    input wire logic [31:0] avs_writedata_i,
    input wire logic [31:0] avs_readdata_o,
    input wire logic        avs_waitrequest_o
);
    logic [1:0] lat_q;
    logic       go;
    logic       rom;
    logic       bad;
    // Taken transfer and target; shadow window kept out of bad
    assign go  = hsel_i && hready_i && htrans_i[1];
    assign rom = haddr_i[31:17] == brm_pkg::ROM_BASE[31:17];
    assign bad = !rom && (|haddr_i[31:12]);
    // Own copy of the wait setting, since the checker cannot see inside
    always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
            lat_q <= brm_pkg::LAT_RST;
        end else if (avs_write_i && !avs_waitrequest_o
                && avs_address_i == brm_pkg::LAT_ADDR) begin
            lat_q <= avs_writedata_i[1:0];
        end
    end
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    chk_zero_wait: assert property (go && rom && lat_q == 2'h0 |=> hreadyout_o)
        else $error("zero wait transfer stalled");
    chk_one_wait: assert property (go && rom && lat_q == 2'h1 |=>
        !hreadyout_o ##1 hreadyout_o) else $error("one wait transfer wrong length");
    // Two wait states, three acts as two
    chk_two_wait: assert property (go && rom && lat_q[1] |=>
        !hreadyout_o [*2] ##1 hreadyout_o) else $error("two wait transfer wrong length");
    chk_rom_okay: assert property (go && rom |=> hresp_o == brm_pkg::HRESP_OKAY)
        else $error("ROM transfer not okay");
    chk_err_pair: assert property (go && bad |=>
        (!hreadyout_o && hresp_o == brm_pkg::HRESP_ERROR) ##1
        (hreadyout_o && hresp_o == brm_pkg::HRESP_ERROR)) else $error("error response malformed");
    chk_data_hold: assert property (!hreadyout_o |-> $stable(hrdata_o))
        else $error("read data moved during wait");
    chk_avs_once: assert property ($rose(avs_read_i || avs_write_i) |=>
        !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("register answer timing wrong");
    chk_lat_read: assert property (avs_read_i && !avs_waitrequest_o &&
        avs_address_i == brm_pkg::LAT_ADDR |-> avs_readdata_o[1:0] == lat_q)
        else $error("wait setting readback wrong");
endmodule : brm_ahb_rom_props
bind brm_ahb_rom brm_ahb_rom_props i_props (
    .clock_i           (clock_i),
    .rst_n_i           (rst_n_i),
    .hsel_i            (hsel_i),
    .haddr_i           (haddr_i),
    .htrans_i          (htrans_i),
    .hready_i          (hready_i),
    .hreadyout_o       (hreadyout_o),
    .hresp_o           (hresp_o),
    .hrdata_o          (hrdata_o),
    .avs_address_i     (avs_address_i),
    .avs_read_i        (avs_read_i),
    .avs_write_i       (avs_write_i),
    .avs_writedata_i   (avs_writedata_i),
    .avs_readdata_o    (avs_readdata_o),
    .avs_waitrequest_o (avs_waitrequest_o)
);

// [verif/brm_ahb_master.sv]
// Behavioural AHB master standing in for the processor or the DMA engine
`timescale 1ns/1ps
module brm_ahb_master (
    input  wire logic        clock_i,
    input  wire logic        hreadyout_i,
    input  wire logic [1:0]  hresp_i,
    input  wire logic [31:0] hrdata_i,
    output logic             hsel_o,
    output logic      [31:0] haddr_o,
    output logic      [1:0]  htrans_o,
    output logic             hwrite_o
);
    // Idle bus at time zero
    initial begin
        hsel_o   = 1'b0;
        haddr_o  = 32'h0;
        htrans_o = 2'h0;
        hwrite_o = 1'b0;
    end
    // Single transfer, gap gives a slow master
    task automatic xfer(input logic [31:0] a, input logic w, input int gap,
                        output logic [31:0] d, output logic [1:0] r);
        repeat (gap + 1) @(posedge clock_i);
        hsel_o   <= 1'b1;
        haddr_o  <= a;
        htrans_o <= 2'h2;
        hwrite_o <= w;
        // Address phase stands until ready is seen high
        do @(posedge clock_i); while (!hreadyout_i);
        // Released address shows its inverse, not a stale copy
        hsel_o   <= 1'b0;
        haddr_o  <= ~a;
        htrans_o <= 2'h0;
        do @(posedge clock_i); while (!hreadyout_i);
        d = hrdata_i;
        r = hresp_i;
    endtask : xfer
endmodule : brm_ahb_master

// [verif/brm_ahb_rom_bench.sv]
// Self-checking bench for the boot ROM slave
`timescale 1ns/1ps
module brm_ahb_rom_bench;
    localparam logic [31:0] FILL = 32'h5a5a_c3c3;
    logic        clock_i, rst_n_i, hsel_i, hwrite_i, hreadyout_o, avs_read_i, avs_write_i;
    logic        avs_waitrequest_o;
    logic [31:0] haddr_i, hrdata_o, avs_address_i, avs_writedata_i, avs_readdata_o;
    logic [1:0]  htrans_i, hresp_o;
    int          n_mismatch = 0, cmp_count = 0, cyc = 0;
    // Single slave, so its ready feeds its own ready input
    brm_ahb_rom #(
        .BOOT_FILL (FILL)
    ) i_dut (
        .clock_i           (clock_i),
        .rst_n_i           (rst_n_i),
        .ce_i              (1'b1),
        .hsel_i            (hsel_i),
        .haddr_i           (haddr_i),
        .htrans_i          (htrans_i),
        .hwrite_i          (hwrite_i),
        .hsize_i           (3'h2),
        .hready_i          (hreadyout_o),
        .hreadyout_o       (hreadyout_o),
        .hresp_o           (hresp_o),
        .hrdata_o          (hrdata_o),
        .avs_address_i     (avs_address_i),
        .avs_read_i        (avs_read_i),
        .avs_write_i       (avs_write_i),
        .avs_writedata_i   (avs_writedata_i),
        .avs_byteenable_i  (4'hf),
        .avs_readdata_o    (avs_readdata_o),
        .avs_waitrequest_o (avs_waitrequest_o)
    );
    brm_ahb_master i_mst (.clock_i(clock_i), .hreadyout_i(hreadyout_o), .hresp_i(hresp_o),
        .hrdata_i(hrdata_o), .hsel_o(hsel_i), .haddr_o(haddr_i), .htrans_o(htrans_i),
        .hwrite_o(hwrite_i));
    initial begin
        clock_i = 1'b0;
        forever #5 clock_i = ~clock_i;
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask : check
    task automatic report_and_stop();
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : report_and_stop
    // Register access, held until waitrequest is seen low
    task automatic avs(input logic [31:0] a, input logic w, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clock_i);
        avs_address_i   <= a;
        avs_read_i      <= !w;
        avs_write_i     <= w;
        avs_writedata_i <= wd;
        do @(posedge clock_i); while (avs_waitrequest_o);
        rd = avs_readdata_o;
        avs_read_i  <= 1'b0;
        avs_write_i <= 1'b0;
    endtask : avs
    // Expected {response, word} of a read
    function automatic logic [33:0] model(input logic [31:0] a, input logic sh);
        logic [14:0] w;
        logic [31:0] c;
        w = a[16:2] - brm_pkg::CRC_IDX;
        c = {24'h0, w[7:0]};
        for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ brm_pkg::CRC_POLY : c >> 1;
        if (sh && a < 32'h1000) return {brm_pkg::HRESP_OKAY, FILL};
        if (a[31:17] != brm_pkg::ROM_BASE[31:17]) return {brm_pkg::HRESP_ERROR, 32'h0};
        if (a[16:2] >= brm_pkg::PT_IDX) return {brm_pkg::HRESP_OKAY, a[13:2], brm_pkg::PT_ATTR};
        if (w < 15'h100) return {brm_pkg::HRESP_OKAY, c};
        return {brm_pkg::HRESP_OKAY, FILL};
    endfunction : model
    // Hang guard, well above the expected run length
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            report_and_stop();
        end
    end
    // Random mix of regions, wait settings, writes and resets
    initial begin
        logic [31:0] a, d;
        logic [33:0] m;
        logic [1:0]  r;
        logic        sh;
        rst_n_i         = 1'b0;
        avs_read_i      = 1'b0;
        avs_write_i     = 1'b0;
        avs_address_i   = 32'h0;
        avs_writedata_i = 32'h0;
        sh              = 1'b1;
        void'($urandom(32'h3e3e1793));
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        for (int i = 0; i < 60; i++) begin
            if (i % 20 == 19) begin
                rst_n_i <= 1'b0;
                @(posedge clock_i);
                rst_n_i <= 1'b1;
                sh = 1'b1;
                avs(brm_pkg::LAT_ADDR, 1'b0, 32'h0, d);
                check("lat reset", d, {30'h0, brm_pkg::LAT_RST});
                avs(brm_pkg::CTRL_ADDR, 1'b0, 32'h0, d);
                check("shadow reset", d, {31'h0, brm_pkg::SHADOW_RST});
                avs(32'h1300_2870, 1'b0, 32'h0, d);
                check("unmapped reg", d, 32'h0);
            end
            // Fresh wait setting before each iteration's transfers
            avs(brm_pkg::LAT_ADDR, 1'b1, $urandom_range(3), d);
            if (i == 30) begin
                avs(brm_pkg::CTRL_ADDR, 1'b1, 32'h0, d);
                sh = 1'b0;
                avs(brm_pkg::CTRL_ADDR, 1'b0, 32'h0, d);
                check("shadow off", d, 32'h0);
            end
            a = $urandom();
            case (i % 4)
                0: a = {20'h0, a[11:2], 2'h0};
                1: a = brm_pkg::CRC_BASE + {21'h0, a[10:2], 2'h0};
                2: a = {15'h0900, a[16:2], 2'h0};
                default: a = a | 32'h4000_0000;
            endcase
            m = model(a, sh);
            // A write first must leave the word intact
            if (i % 7 == 0) begin
                i_mst.xfer(a, 1'b1, 0, d, r);
                check("write hresp", {30'h0, r}, {30'h0, m[33:32]});
            end
            i_mst.xfer(a, 1'b0, i % 3, d, r);
            check("hresp", {30'h0, r}, {30'h0, m[33:32]});
            if (r === brm_pkg::HRESP_OKAY) check("hrdata", d, m[31:0]);
            // Sticky write flag, then write-one clear
            if (i % 7 == 0) begin
                avs(brm_pkg::STAT_ADDR, 1'b0, 32'h0, d);
                check("wr seen", d, {30'h0, m[33:32] == brm_pkg::HRESP_OKAY, 1'b0});
                avs(brm_pkg::STAT_ADDR, 1'b1, 32'h0000_0002, d);
                avs(brm_pkg::STAT_ADDR, 1'b0, 32'h0, d);
                check("wr clear", d, 32'h0);
            end
        end
        report_and_stop();
    end
endmodule : brm_ahb_rom_bench
